//--- plld_pkg.sv
// Constants, field layouts and timing counts for the lock detector block.
// Assumes a single 25 MHz clock and a simple strobe register port.
//
// Contract
// - Lock only after programmed consecutive good cycles.
// - Single cycle beyond unlock threshold drops lock.
// - Unlock threshold wider than lock threshold.
// - Window from range bit and antibacklash only.
// - Lock flag routable to three pin selectors.
// - Current-source mode: source when locked, else ground.
// - Any lock drop discharges pin at once.
// - Pin comparator selectable on monitor/status, either polarity.
// - Both dividers have three-bit enableable delay.
// - Analog lock pulse polarity per channel variant.
// - Counter code zero needs five good cycles.
// - Disable bit set forces lock flag off.
// - Pattern 000100 selects current-source mode.
package plld_pkg;
	// Register offsets, as printed.
	localparam logic [7:0] PLLD_OFS_STATUS_CTL = 8'h17;
	localparam logic [7:0] PLLD_OFS_LOCK_CTL   = 8'h18;
	localparam logic [7:0] PLLD_OFS_DELAY_CTL  = 8'h19;
	localparam logic [7:0] PLLD_OFS_LDPIN_CTL  = 8'h1a;
	localparam logic [7:0] PLLD_OFS_MON_CTL    = 8'h1b;
	// Own registers: event status, event mask, live state.
	localparam logic [7:0] PLLD_OFS_IRQ_STAT   = 8'h40;
	localparam logic [7:0] PLLD_OFS_IRQ_MASK   = 8'h41;
	localparam logic [7:0] PLLD_OFS_STATE      = 8'h42;
	// Field positions inside the lock control register.
	localparam int PLLD_CNT_LSB   = 5;
	localparam int PLLD_RANGE_BIT = 4;
	localparam int PLLD_DIS_BIT   = 3;
	// Output selector codes (six bits for lock pin and status, five for monitor).
	localparam logic [5:0] PLLD_SEL_LOW      = 6'h00;
	localparam logic [5:0] PLLD_SEL_DLD      = 6'h01;
	localparam logic [5:0] PLLD_SEL_ALD_N    = 6'h02;
	localparam logic [5:0] PLLD_SEL_ALD_P    = 6'h03;
	localparam logic [5:0] PLLD_SEL_CURSRC   = 6'h04;
	localparam logic [5:0] PLLD_SEL_HIGH     = 6'h05;
	localparam logic [5:0] PLLD_SEL_CMP_HI   = 6'h06;
	localparam logic [5:0] PLLD_SEL_CMP_LO   = 6'h07;
	localparam logic [5:0] PLLD_SEL_DLD_LO   = 6'h08;
	// Good-cycle counts for lock counter codes 0..3.
	localparam logic [7:0] PLLD_CNT0 = 8'h05;
	localparam logic [7:0] PLLD_CNT1 = 8'h10;
	localparam logic [7:0] PLLD_CNT2 = 8'h40;
	localparam logic [7:0] PLLD_CNT3 = 8'hff;
	// Phase error thresholds in clock cycles; unlock exceeds lock.
	localparam logic [7:0] PLLD_LOCK_THR_HI   = 8'h02;
	localparam logic [7:0] PLLD_UNLOCK_THR_HI = 8'h04;
	localparam logic [7:0] PLLD_LOCK_THR_LO   = 8'h01;
	localparam logic [7:0] PLLD_UNLOCK_THR_LO = 8'h02;
	// Analog lock pulse width: 80 ns at 25 MHz.
	localparam int PLLD_CLK_MHZ    = 25;
	localparam int PLLD_ALD_NS     = 80;
	localparam logic [7:0] PLLD_ALD_CYC = 8'((PLLD_ALD_NS * PLLD_CLK_MHZ) / 1000);
	// Reset values.
	localparam logic [7:0] PLLD_LOCK_CTL_RST = 8'h00;
	localparam logic [7:0] PLLD_SEL_RST      = 8'h00;
	// Lock detector states.
	typedef enum logic [1:0] {PLLD_UNLOCKED, PLLD_COUNTING, PLLD_LOCKED} plld_state_t;
endpackage

//--- plld_top.sv
// Digital lock detector, pin routing, current-source lock pin and delay codes.
// Assumes comparator edges arrive asynchronously on pins; registers on a strobe port.
`timescale 1ns/100ps
`default_nettype none
module plld_top
	import plld_pkg::*;
(
	input  wire logic       clock_i,        // System clock, 25 MHz.
	input  wire logic       rst_b_i,        // Asynchronous reset, active low.
	input  wire logic [7:0] addr_i,         // Register address.
	input  wire logic [7:0] wdata_i,        // Write data.
	input  wire logic       wr_i,           // Write strobe.
	input  wire logic       rd_i,           // Read strobe.
	output logic      [7:0] rdata_o,        // Read data, cycle after strobe.
	input  wire logic       ref_edge_i,     // Reference divider output at comparator.
	input  wire logic       fb_edge_i,      // Feedback divider output at comparator.
	input  wire logic       ldpin_cmp_i,    // Internal comparator on lock pin voltage.
	output logic            lock_pin_o,     // Lock indicator pin level.
	output logic            lock_pin_oe_o,  // Lock indicator pin drive enable.
	output logic            status_pin_o,   // Status pin.
	output logic            reference_monitor_pin_pin_o,   // Reference monitor pin.
	output logic            digital_lock_o, // Digital lock flag.
	output logic      [3:0] ref_delay_o,    // Enable plus three-bit reference delay.
	output logic      [3:0] fb_delay_o,     // Enable plus three-bit feedback delay.
	output logic            irq_o           // Level interrupt.
);
	// Control registers.
	logic [7:0]  status_ctl;   // Status selector and antibacklash setting.
	logic [7:0]  lock_ctl;     // Counter code, range, disable.
	logic [7:0]  delay_ctl;    // Divider delay codes.
	logic [5:0]  ldpin_ctl;    // Lock pin selector.
	logic [4:0]  mon_ctl;      // Monitor pin selector.
	logic [2:0]  irq_stat;     // Sticky events: lock, unlock, bad cycle.
	logic [2:0]  irq_mask;     // Interrupt mask.
	// Synchronisers, three flops each; stage one feeds only stage two.
	logic [2:0]  sync_ref;
	logic [2:0]  sync_fb;
	logic [2:0]  sync_cmp;
	logic        ref_lvl;      // Debounced reference level.
	logic        fb_lvl;       // Debounced feedback level.
	logic        cmp_lvl;      // Debounced comparator level.
	logic        ref_rise;     // Reference rising edge.
	logic        fb_rise;      // Feedback rising edge.
	// Phase measurement.
	logic [7:0]  diff_cnt;     // Cycles since first edge of a pair.
	logic        pending;      // One edge seen, waiting for its partner.
	logic        cyc_done;     // One comparator cycle measured.
	logic [7:0]  cyc_diff;     // Its edge time difference.
	plld_state_t state;
	logic [7:0]  good_cnt;     // Consecutive good cycles.
	logic        locked;
	logic [7:0]  need_cnt;
	logic [7:0]  lock_thr;
	logic [7:0]  unlock_thr;
	logic        lock_ev;
	logic        unlock_ev;
	logic [7:0]  ald_cnt;      // Analog pulse stretcher.
	logic        ald_pulse;
	logic        next_lock_pin;
	logic        next_lock_oe;

	// Three-flop synchronisers; a level changes once stages two and three agree.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_ref <= 3'h0;
			sync_fb  <= 3'h0;
			sync_cmp <= 3'h0;
		end else begin
			sync_ref <= {sync_ref[1:0], ref_edge_i};
			sync_fb  <= {sync_fb[1:0], fb_edge_i};
			sync_cmp <= {sync_cmp[1:0], ldpin_cmp_i};
		end
	end

	// Agreed levels held in flops so glitches on stage two are filtered.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_lvl <= 1'b0;
			fb_lvl  <= 1'b0;
			cmp_lvl <= 1'b0;
		end else begin
			if (sync_ref[1] == sync_ref[2]) ref_lvl <= sync_ref[2];
			if (sync_fb[1] == sync_fb[2]) fb_lvl <= sync_fb[2];
			if (sync_cmp[1] == sync_cmp[2]) cmp_lvl <= sync_cmp[2];
		end
	end

	assign ref_rise = (sync_ref[1] == sync_ref[2]) && sync_ref[2] && !ref_lvl;
	assign fb_rise  = (sync_fb[1] == sync_fb[2]) && sync_fb[2] && !fb_lvl;

	// Window from settings.
	// The range bit picks the threshold pair; wider antibacklash widens both by one.
	always_comb begin
		if (lock_ctl[PLLD_RANGE_BIT]) begin
			lock_thr   = PLLD_LOCK_THR_LO + {7'h00, status_ctl[1]};
			unlock_thr = PLLD_UNLOCK_THR_LO + {7'h00, status_ctl[1]};
		end else begin
			lock_thr   = PLLD_LOCK_THR_HI + {7'h00, status_ctl[1]};
			unlock_thr = PLLD_UNLOCK_THR_HI + {7'h00, status_ctl[1]};
		end
	end

	always_comb begin
		case (lock_ctl[PLLD_CNT_LSB +: 2])
			2'h0:    need_cnt = PLLD_CNT0;
			2'h1:    need_cnt = PLLD_CNT1;
			2'h2:    need_cnt = PLLD_CNT2;
			default: need_cnt = PLLD_CNT3;
		endcase
	end

	// Measures the time between the two rising edges of each comparator cycle; edges
	// in one cycle measure zero. A missing partner saturates into a bad cycle, which
	// relies on the configuring side keeping the period above the unlock threshold.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pending  <= 1'b0;
			diff_cnt <= 8'h00;
			cyc_done <= 1'b0;
			cyc_diff <= 8'h00;
		end else begin
			cyc_done <= 1'b0;
			if (ref_rise && fb_rise) begin
				pending  <= 1'b0;
				cyc_done <= 1'b1;
				cyc_diff <= 8'h00;
			end else if (ref_rise || fb_rise) begin
				if (pending) begin
					pending  <= 1'b0;
					cyc_done <= 1'b1;
					cyc_diff <= diff_cnt;
				end else begin
					pending  <= 1'b1;
					diff_cnt <= 8'h01;
				end
			end else if (pending && diff_cnt != 8'hff) begin
				diff_cnt <= diff_cnt + 8'h01;
			end
		end
	end

	// Lock state machine.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state    <= PLLD_UNLOCKED;
			good_cnt <= 8'h00;
		end else if (lock_ctl[PLLD_DIS_BIT]) begin
			state    <= PLLD_UNLOCKED;
			good_cnt <= 8'h00;
		end else if (cyc_done) begin
			case (state)
				PLLD_UNLOCKED, PLLD_COUNTING: begin
					if (cyc_diff < lock_thr) begin
						if (good_cnt + 8'h01 >= need_cnt) begin
							state    <= PLLD_LOCKED;
							good_cnt <= 8'h00;
						end else begin
							state    <= PLLD_COUNTING;
							good_cnt <= good_cnt + 8'h01;
						end
					end else begin
						state    <= PLLD_UNLOCKED;
						good_cnt <= 8'h00;
					end
				end
				PLLD_LOCKED: begin
					// Single bad cycle beyond the wider unlock threshold.
					if (cyc_diff > unlock_thr) begin
						state <= PLLD_UNLOCKED;
					end
				end
				default: begin
					state    <= PLLD_UNLOCKED;
					good_cnt <= 8'h00;
				end
			endcase
		end
	end

	assign locked    = (state == PLLD_LOCKED);
	assign lock_ev   = locked && !digital_lock_o;
	assign unlock_ev = !locked && digital_lock_o;

	// Analog lock pulse: stretches each measured phase error so it is visible.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ald_cnt   <= 8'h00;
			ald_pulse <= 1'b0;
		end else if (cyc_done && cyc_diff != 8'h00) begin
			ald_cnt   <= PLLD_ALD_CYC;
			ald_pulse <= 1'b1;
		end else if (ald_cnt != 8'h00) begin
			ald_cnt   <= ald_cnt - 8'h01;
			ald_pulse <= (ald_cnt != 8'h01);
		end else begin
			ald_pulse <= 1'b0;
		end
	end

	// Lock pin selector.
	always_comb begin
		next_lock_pin = 1'b0;
		next_lock_oe  = 1'b1;
		case (ldpin_ctl)
			PLLD_SEL_DLD:  next_lock_pin = locked;
			// Idle high, low pulses; open drain drives only low.
			PLLD_SEL_ALD_N: begin
				next_lock_pin = 1'b0;
				next_lock_oe  = ald_pulse;
			end
			// Idle low, high pulses; open drain drives only high.
			PLLD_SEL_ALD_P: begin
				next_lock_pin = 1'b1;
				next_lock_oe  = ald_pulse;
			end
			// Source while locked, ground at once otherwise.
			PLLD_SEL_CURSRC: next_lock_pin = locked;
			PLLD_SEL_HIGH:  next_lock_pin = 1'b1;
			default:        next_lock_pin = 1'b0;
		endcase
	end

	// Pin and flag outputs, all registered.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lock_pin_o     <= 1'b0;
			lock_pin_oe_o  <= 1'b1;
			status_pin_o   <= 1'b0;
			reference_monitor_pin_pin_o   <= 1'b0;
			digital_lock_o <= 1'b0;
		end else begin
			lock_pin_o     <= next_lock_pin;
			lock_pin_oe_o  <= next_lock_oe;
			digital_lock_o <= locked;
			case (status_ctl[7:2])
				PLLD_SEL_DLD:    status_pin_o <= locked;
				PLLD_SEL_DLD_LO: status_pin_o <= !locked;
				PLLD_SEL_CMP_HI: status_pin_o <= cmp_lvl;
				PLLD_SEL_CMP_LO: status_pin_o <= !cmp_lvl;
				PLLD_SEL_HIGH:   status_pin_o <= 1'b1;
				default:         status_pin_o <= 1'b0;
			endcase
			case ({1'b0, mon_ctl})
				PLLD_SEL_DLD:    reference_monitor_pin_pin_o <= locked;
				PLLD_SEL_DLD_LO: reference_monitor_pin_pin_o <= !locked;
				PLLD_SEL_CMP_HI: reference_monitor_pin_pin_o <= cmp_lvl;
				PLLD_SEL_CMP_LO: reference_monitor_pin_pin_o <= !cmp_lvl;
				PLLD_SEL_HIGH:   reference_monitor_pin_pin_o <= 1'b1;
				default:         reference_monitor_pin_pin_o <= 1'b0;
			endcase
		end
	end

	// Divider delay codes.
	// Bits 3 and 7 enable; bits 2:0 and 6:4 are the three-bit codes.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_delay_o <= 4'h0;
			fb_delay_o  <= 4'h0;
		end else begin
			ref_delay_o <= delay_ctl[3:0];
			fb_delay_o  <= delay_ctl[7:4];
		end
	end

	// Register writes. A write of ones clears status, but events win.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_ctl <= PLLD_SEL_RST;
			lock_ctl   <= PLLD_LOCK_CTL_RST;
			delay_ctl  <= 8'h00;
			ldpin_ctl  <= 6'h00;
			mon_ctl    <= 5'h00;
			irq_mask   <= 3'h0;
		end else if (wr_i) begin
			case (addr_i)
				PLLD_OFS_STATUS_CTL: status_ctl <= wdata_i;
				PLLD_OFS_LOCK_CTL:   lock_ctl   <= wdata_i;
				PLLD_OFS_DELAY_CTL:  delay_ctl  <= wdata_i;
				PLLD_OFS_LDPIN_CTL:  ldpin_ctl  <= wdata_i[5:0];
				PLLD_OFS_MON_CTL:    mon_ctl    <= wdata_i[4:0];
				PLLD_OFS_IRQ_MASK:   irq_mask   <= wdata_i[2:0];
				default:             ;
			endcase
		end
	end

	// Sticky event bits; a set in the clearing cycle survives.
	// The interrupt level follows the masked status one cycle later.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_stat <= 3'h0;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~((wr_i && addr_i == PLLD_OFS_IRQ_STAT) ? wdata_i[2:0] : 3'h0))
				| {cyc_done && cyc_diff > unlock_thr, unlock_ev, lock_ev};
			irq_o    <= |(irq_stat & irq_mask);
		end
	end

	// Read data, valid the cycle after the strobe only; unmapped reads zero.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				PLLD_OFS_STATUS_CTL: rdata_o <= status_ctl;
				PLLD_OFS_LOCK_CTL:   rdata_o <= lock_ctl;
				PLLD_OFS_DELAY_CTL:  rdata_o <= delay_ctl;
				PLLD_OFS_LDPIN_CTL:  rdata_o <= {2'h0, ldpin_ctl};
				PLLD_OFS_MON_CTL:    rdata_o <= {3'h0, mon_ctl};
				PLLD_OFS_IRQ_STAT:   rdata_o <= {5'h00, irq_stat};
				PLLD_OFS_IRQ_MASK:   rdata_o <= {5'h00, irq_mask};
				PLLD_OFS_STATE:      rdata_o <= {5'h00, cmp_lvl, pending, locked};
				default:             rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Checks.
	property p_reset_unlocked;
		@(posedge clock_i) $rose(rst_b_i) |-> !locked && good_cnt == 8'h00;
	endproperty
	a_reset_unlocked: assert property (p_reset_unlocked) else $error("not unlocked after reset");
	property p_disable_off;
		@(posedge clock_i) disable iff (!rst_b_i) lock_ctl[PLLD_DIS_BIT] |=> !locked;
	endproperty
	a_disable_off: assert property (p_disable_off) else $error("lock with detector disabled");
	property p_lock_needs_good;
		@(posedge clock_i) disable iff (!rst_b_i)
			$rose(locked) |-> $past(cyc_done) && $past(cyc_diff) < $past(lock_thr);
	endproperty
	a_lock_needs_good: assert property (p_lock_needs_good) else $error("lock without good cycle");
	property p_unlock_single;
		@(posedge clock_i) disable iff (!rst_b_i)
			locked && cyc_done && cyc_diff > unlock_thr && !lock_ctl[PLLD_DIS_BIT] |=> !locked;
	endproperty
	a_unlock_single: assert property (p_unlock_single) else $error("lock kept after bad cycle");
	property p_hysteresis;
		@(posedge clock_i) disable iff (!rst_b_i) unlock_thr > lock_thr;
	endproperty
	a_hysteresis: assert property (p_hysteresis) else $error("no hysteresis");
	property p_five_cycles;
		@(posedge clock_i) disable iff (!rst_b_i)
			$rose(locked) && lock_ctl[PLLD_CNT_LSB +: 2] == 2'h0 |-> $past(good_cnt) == 8'h04;
	endproperty
	a_five_cycles: assert property (p_five_cycles) else $error("code zero not five cycles");
	property p_cursrc_drop;
		@(posedge clock_i) disable iff (!rst_b_i)
			ldpin_ctl == PLLD_SEL_CURSRC && !locked |=> !lock_pin_o;
	endproperty
	a_cursrc_drop: assert property (p_cursrc_drop) else $error("pin not discharged");
	property p_cursrc_src;
		@(posedge clock_i) disable iff (!rst_b_i)
			ldpin_ctl == PLLD_SEL_CURSRC && locked |=> lock_pin_o && lock_pin_oe_o;
	endproperty
	a_cursrc_src: assert property (p_cursrc_src) else $error("pin not sourcing");
endmodule
`default_nettype wire

//--- plld_cap_model.sv
// Behavioural capacitor and pull resistor hanging on the lock indicator pin.
// Assumes one clock; the bench picks the resistor's pull level per pin mode.
`timescale 1ns/100ps
`default_nettype none
module plld_cap_model #(
	parameter int CHARGE_CYC = 20 // Cycles of sourcing before the trip point.
) (
	input  wire logic clock_i,   // System clock.
	input  wire logic rst_b_i,   // Reset, active low.
	input  wire logic pin_i,     // Level driven by the block.
	input  wire logic oe_i,      // Drive enable of the block.
	input  wire logic pull_up_i, // Resistor pulls up when high, else down.
	output logic      level_o,   // Resolved pin level.
	output logic      cmp_o      // Capacitor voltage above the trip point.
);
	int charge; // Charge in cycles of sourcing.
	// A released pin settles to the resistor's level, never the last value.
	assign level_o = oe_i ? pin_i : pull_up_i;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			charge <= 0;
		end else if (oe_i && !pin_i) begin
			charge <= 0; // A grounded pin empties the capacitor at once.
		end else if (oe_i && charge < CHARGE_CYC) begin
			charge <= charge + 1; // Saturates so the count cannot wrap.
		end
	end
	assign cmp_o = (charge >= CHARGE_CYC);
endmodule
`default_nettype wire

//--- pll_lock_detect_test.sv
// Self-checking bench for the lock detector with a capacitor on its lock pin.
// Assumes the strobe register port and a 25 MHz clock; no second clock.
`timescale 1ns/100ps
`default_nettype none
module pll_lock_detect_test;
	import plld_pkg::*;
	logic clock_i, rst_b_i, wr_i, rd_i, ref_i, fb_i, pull, rd_d, cnt_en, cnt_val;
	logic [7:0] addr_i, wdata_i, rdata_o, v;
	logic lp, lp_oe, st, rm, dl, irq, cmp, lvl;
	logic [3:0] rdl, fdl;
	logic [7:0] eq[$], mq[$]; // Expected read data and compare mask.
	int miscompares, check_count, cyc, cnt;
	logic [7:0] cnts[4] = '{PLLD_CNT0, PLLD_CNT1, PLLD_CNT2, PLLD_CNT3};
	plld_top u_plld_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref_edge_i(ref_i),
		.fb_edge_i(fb_i), .ldpin_cmp_i(cmp), .lock_pin_o(lp), .lock_pin_oe_o(lp_oe),
		.status_pin_o(st), .reference_monitor_pin_pin_o(rm), .digital_lock_o(dl), .ref_delay_o(rdl),
		.fb_delay_o(fdl), .irq_o(irq));
	plld_cap_model u_plld_cap_model (.clock_i(clock_i), .rst_b_i(rst_b_i), .pin_i(lp),
		.oe_i(lp_oe), .pull_up_i(pull), .level_o(lvl), .cmp_o(cmp));
	// Free running clock, 40 ns period.
	initial begin
		clock_i = 0;
		forever #20 clock_i = ~clock_i;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe; compare there.
	always @(posedge clock_i) begin
		rd_d <= rd_i;
		if (rd_d) begin
			chk("rdata", eq[0] & mq[0], rdata_o & mq[0]);
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
		if (cnt_en && lvl === cnt_val) cnt++;
		cyc++;
		if (cyc == 20000) begin
			miscompares++; // A hang counts as a mismatch.
			complete_run();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		eq.push_back(e);
		mq.push_back(m);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask
	// One comparator period: feedback edge d clocks after reference edge.
	// The period of d plus 15 clocks stays above the unlock threshold.
	task automatic phase_frequency_comparator(input int d);
		@(posedge clock_i);
		ref_i <= 1'b1;
		fb_i <= (d == 0);
		if (d > 0) begin
			repeat (d) @(posedge clock_i);
			fb_i <= 1'b1;
		end
		repeat (6) @(posedge clock_i);
		ref_i <= 1'b0;
		fb_i <= 1'b0;
		repeat (8) @(posedge clock_i);
	endtask
	// Lock flag and its three routed copies.
	task automatic lk(input logic e);
		chk("lock", {7'h0, e}, {7'h0, dl});
		chk("pins", {5'h0, e, e, e}, {5'h0, lp, st, rm});
	endtask
	initial begin
		{wr_i, rd_i, ref_i, fb_i, rd_d, cnt_en, cnt_val, cnt, cyc} = '0;
		{addr_i, wdata_i, miscompares, check_count} = '0;
		pull = 1'b1;
		rst_b_i = 1'b0;
		repeat (8) @(posedge clock_i);
		rst_b_i <= 1'b1;
		v = 8'($urandom(93));
		@(posedge clock_i);
		chk("lock", 8'h0, {7'h0, dl});
		rd(PLLD_OFS_LOCK_CTL, PLLD_LOCK_CTL_RST, 8'hff);
		rd(8'h55, 8'h00, 8'hff);
		wr(PLLD_OFS_LDPIN_CTL, 8'(PLLD_SEL_DLD));
		wr(PLLD_OFS_MON_CTL, 8'(PLLD_SEL_DLD));
		wr(PLLD_OFS_STATUS_CTL, 8'(PLLD_SEL_DLD) << 2);
		// Each counter code: one short of the count stays unlocked.
		for (int c = 0; c < 4; c++) begin
			wr(PLLD_OFS_LOCK_CTL, 8'(c << PLLD_CNT_LSB));
			phase_frequency_comparator(5);
			lk(1'b0);
			repeat (cnts[c] - 1) phase_frequency_comparator($urandom % 2);
			lk(1'b0);
			phase_frequency_comparator($urandom % 2);
			lk(1'b1);
		end
		phase_frequency_comparator(4);
		lk(1'b1);
		phase_frequency_comparator(5);
		lk(1'b0);
		// Narrow window: difference one never counts, three unlocks.
		wr(PLLD_OFS_LOCK_CTL, 8'h10);
		repeat (5) phase_frequency_comparator(1);
		lk(1'b0);
		repeat (5) phase_frequency_comparator(0);
		lk(1'b1);
		phase_frequency_comparator(2);
		lk(1'b1);
		phase_frequency_comparator(3);
		lk(1'b0);
		// Wide antibacklash widens both thresholds by one clock.
		wr(PLLD_OFS_STATUS_CTL, (8'(PLLD_SEL_DLD) << 2) | 8'h02);
		repeat (5) phase_frequency_comparator(1);
		lk(1'b1);
		phase_frequency_comparator(3);
		lk(1'b1);
		phase_frequency_comparator(4);
		lk(1'b0);
		wr(PLLD_OFS_STATUS_CTL, 8'(PLLD_SEL_DLD) << 2);
		repeat (5) phase_frequency_comparator(0);
		wr(PLLD_OFS_LOCK_CTL, 8'h18);
		repeat (6) @(posedge clock_i);
		lk(1'b0);
		phase_frequency_comparator(0);
		lk(1'b0);
		wr(PLLD_OFS_LOCK_CTL, 8'h00);
		// Current source with the pin comparator on both monitor pins.
		wr(PLLD_OFS_LDPIN_CTL, 8'(PLLD_SEL_CURSRC));
		wr(PLLD_OFS_MON_CTL, 8'(PLLD_SEL_CMP_HI));
		wr(PLLD_OFS_STATUS_CTL, 8'(PLLD_SEL_CMP_LO) << 2);
		repeat (5) phase_frequency_comparator(0);
		chk("src", 8'h3, {6'h0, lp, lp_oe});
		repeat (40) @(posedge clock_i);
		chk("cmp", 8'h2, {6'h0, rm, st});
		phase_frequency_comparator(5);
		chk("gnd", 8'h1, {6'h0, lp, lp_oe});
		chk("cmp", 8'h1, {6'h0, rm, st});
		repeat (5) phase_frequency_comparator(0);
		chk("cmp", 8'h1, {6'h0, rm, st});
		repeat (40) @(posedge clock_i);
		chk("cmp", 8'h2, {6'h0, rm, st});
		// Interrupt: sticky unlock bit, masked, unmasked, cleared.
		wr(PLLD_OFS_IRQ_MASK, 8'h00);
		wr(PLLD_OFS_IRQ_STAT, 8'h07);
		rd(PLLD_OFS_IRQ_STAT, 8'h00, 8'h07);
		phase_frequency_comparator(5);
		rd(PLLD_OFS_IRQ_STAT, 8'h06, 8'h07);
		chk("irq", 8'h0, {7'h0, irq});
		wr(PLLD_OFS_IRQ_MASK, 8'h02);
		repeat (3) @(posedge clock_i);
		chk("irq", 8'h1, {7'h0, irq});
		wr(PLLD_OFS_IRQ_STAT, 8'h02);
		repeat (3) @(posedge clock_i);
		chk("irq", 8'h0, {7'h0, irq});
		// Analog pulse modes: idle level and pulse width on the wire.
		for (int i = 0; i < 2; i++) begin
			wr(PLLD_OFS_LDPIN_CTL, 8'(i ? PLLD_SEL_ALD_P : PLLD_SEL_ALD_N));
			pull <= !i;
			cnt_val <= i;
			repeat (4) @(posedge clock_i);
			chk("idle", {7'h0, !i[0]}, {7'h0, lvl});
			cnt = 0;
			cnt_en <= 1'b1;
			phase_frequency_comparator(1);
			cnt_en <= 1'b0;
			chk("pulse", PLLD_ALD_CYC, 8'(cnt));
		end
		// Delay codes pass through to both divider outputs.
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(PLLD_OFS_DELAY_CTL, v);
			repeat (2) @(posedge clock_i);
			chk("delay", v, {fdl, rdl});
			rd(PLLD_OFS_DELAY_CTL, v, 8'hff);
		end
		// Inverted lock flag on status, fixed high on the other two pins.
		wr(PLLD_OFS_STATUS_CTL, 8'(PLLD_SEL_DLD_LO) << 2);
		wr(PLLD_OFS_MON_CTL, 8'(PLLD_SEL_HIGH));
		wr(PLLD_OFS_LDPIN_CTL, 8'(PLLD_SEL_HIGH));
		repeat (3) @(posedge clock_i);
		chk("sel", 8'h7, {5'h0, lp, st, rm});
		repeat (4) @(posedge clock_i);
		complete_run();
	end
endmodule
`default_nettype wire
